/* File: src/bcm_crc_map.sv */
// bcm_crc_map: write frame capture, crc tree input mapping and error flag
// Operation
// - byte lane: four data, four ones, crc, one
// - start bit 0: mask nibble low, else ones
// - start bit 1: data moves to upper nibble
// - start bit 1: mask nibble high, else ones
// - wide device: two identical independent crc trees
// - wide, start 0: upper mask low nibble
// - wide, start 1: upper mask high nibble
// - wide: crc byte per lane group, ones after
// - chopped burst reuses full tree, ones elsewhere
// - separate input maps per start bit value
// - start bit picks which half comes first
// - lower crc covers low half, upper high
// - mismatch sets sticky status until cleared
`timescale 1ns/100ps
module bcm_crc_map (
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          frame_start_i,
  input  wire bcm_pkg::bcm_beat_type         beat_i,
  input  wire bcm_pkg::bcm_mode_type         mode_i,
  input  wire logic                          status_clear_i,
  output logic                               crc_error_pulse_o,
  output logic                               crc_error_status_o,
  output logic [bcm_pkg::CRC_WIDTH*2-1:0]    crc_computed_o,
  output logic                               frame_busy_o
);

  // ---------------------------------------------------------------
  // crc-8 tree, input bit 71 shifted in first, bit 0 last
  // ---------------------------------------------------------------
  function automatic logic [7:0] bcm_tree(input logic [bcm_pkg::TREE_WIDTH-1:0] d);
    logic [7:0] c;
    c = '0;
    for (int i = bcm_pkg::TREE_WIDTH - 1; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ bcm_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bcm_pkg::bcm_state_type              state_reg, state_next;
  logic [2:0]                          beat_reg, beat_next;
  bcm_pkg::bcm_mode_type               mode_reg, mode_next;
  logic [bcm_pkg::FULL_WIDTH-1:0]      data_reg, data_next;
  logic                                pulse_reg, pulse_next;
  logic                                status_reg, status_next;
  logic [bcm_pkg::CRC_WIDTH*2-1:0]     crc_reg, crc_next;

  bcm_pkg::bcm_mode_type               cur_mode;
  logic                                start_take;
  logic                                capture;
  logic [2:0]                          slot;
  logic [bcm_pkg::LANE_COUNT-1:0]      lane_bits;
  logic [bcm_pkg::FULL_WIDTH-1:0]      map_data;
  logic [bcm_pkg::CRC_WIDTH*2-1:0]     tree_out;
  logic [bcm_pkg::CRC_WIDTH*2-1:0]     crc_rx;
  logic                                mismatch;

  assign start_take = frame_start_i &&
                      (state_reg == bcm_pkg::ST_IDLE || state_reg == bcm_pkg::ST_TAIL);
  assign cur_mode   = start_take ? mode_i : mode_reg;
  assign lane_bits  = {beat_i.upper_mask_inversion_pin, beat_i.dq[15:8],
                       beat_i.lower_mask_inversion_pin, beat_i.dq[7:0]};

  // a chopped burst only carries beats 0..3; beats 4..7 are fixed ones
  assign capture = start_take ||
                   (state_reg == bcm_pkg::ST_DATA &&
                    (!mode_reg.burst_chop_four || beat_reg < bcm_pkg::CHOP_BEATS));

  // start bit 1 steers beats into the upper nibble
  assign slot = (cur_mode.burst_chop_four && cur_mode.start_column_bit) ?
                (beat_next - 3'h1 + bcm_pkg::UPPER_HALF) : (beat_next - 3'h1);

  // ---------------------------------------------------------------
  // per-lane slot placement
  // ---------------------------------------------------------------
  for (genvar ln = 0; ln < bcm_pkg::LANE_COUNT; ln++) begin : g_lane
    logic [7:0] base;
    logic       keep_one;
    always_comb begin
      base = start_take ? bcm_pkg::SLOTS_ONES : data_reg[ln*8 +: 8];
      keep_one = 1'b0;
      // mask lanes count only with mask or inversion enabled
      if (ln == bcm_pkg::LOWER_MASK || ln == bcm_pkg::UPPER_MASK) begin
        keep_one = !(cur_mode.mask_enable || cur_mode.inversion_enable);
      end
      // narrow device leaves the upper tree at ones
      if (ln > bcm_pkg::LOWER_MASK && !cur_mode.wide_device) begin
        keep_one = 1'b1;
      end
      if (capture && !keep_one) begin
        base[slot] = lane_bits[ln];
      end
      map_data[ln*8 +: 8] = base;
    end
  end

  // two identical independent trees
  for (genvar tr = 0; tr < bcm_pkg::TREE_COUNT; tr++) begin : g_tree
    assign tree_out[tr*8 +: 8] = bcm_tree(data_reg[tr*bcm_pkg::TREE_WIDTH +: bcm_pkg::TREE_WIDTH]);
  end

  // received crc: low byte on lower lanes, high byte on upper lanes
  assign crc_rx   = beat_i.dq;
  assign mismatch = (tree_out[7:0] != crc_rx[7:0]) ||
                    (mode_reg.wide_device && tree_out[15:8] != crc_rx[15:8]);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    beat_next   = beat_reg;
    mode_next   = cur_mode;
    data_next   = map_data;
    pulse_next  = 1'b0;
    crc_next    = crc_reg;
    status_next = status_clear_i ? 1'b0 : status_reg;
    case (state_reg)
      bcm_pkg::ST_IDLE, bcm_pkg::ST_TAIL: begin
        state_next = bcm_pkg::ST_IDLE;
        // transfer 0 takes slot 0, so index plus one stays 1
        beat_next  = 3'h1;
        if (start_take) begin
          state_next = bcm_pkg::ST_DATA;
        end
      end
      bcm_pkg::ST_DATA: begin
        beat_next = beat_reg + 3'h1;
        if (beat_reg == bcm_pkg::LAST_DATA) begin
          state_next = bcm_pkg::ST_CRC;
        end
      end
      bcm_pkg::ST_CRC: begin
        state_next = bcm_pkg::ST_TAIL;
        crc_next   = tree_out;
        if (mismatch) begin
          pulse_next  = 1'b1;
          status_next = 1'b1; // set wins over clear
        end
      end
      default: state_next = bcm_pkg::ST_IDLE;
    endcase
  end

  // beat_next during capture is the index plus one
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg  <= bcm_pkg::ST_IDLE;
      beat_reg   <= 3'h1;
      mode_reg   <= '0;
      data_reg   <= '1;
      pulse_reg  <= 1'b0;
      status_reg <= 1'b0;
      crc_reg    <= '0;
    end else begin
      state_reg  <= state_next;
      beat_reg   <= beat_next;
      mode_reg   <= mode_next;
      data_reg   <= data_next;
      pulse_reg  <= pulse_next;
      status_reg <= status_next;
      crc_reg    <= crc_next;
    end
  end

  assign crc_error_pulse_o  = pulse_reg;
  assign crc_error_status_o = status_reg;
  assign crc_computed_o     = crc_reg;
  assign frame_busy_o       = (state_reg == bcm_pkg::ST_DATA) || (state_reg == bcm_pkg::ST_CRC);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic in_crc, chop_low, chop_high, no_mask;
  assign in_crc    = state_reg == bcm_pkg::ST_CRC;
  assign no_mask   = !(mode_reg.mask_enable || mode_reg.inversion_enable);
  assign chop_low  = in_crc && mode_reg.burst_chop_four && !mode_reg.start_column_bit;
  assign chop_high = in_crc && mode_reg.burst_chop_four && mode_reg.start_column_bit;

  sequence s_chop_start;
    start_take && mode_i.burst_chop_four;
  endsequence
  sequence s_reach_crc;
    ##8 in_crc ##1 (state_reg == bcm_pkg::ST_TAIL);
  endsequence

  AST_FRAME_LENGTH: assert property (s_chop_start |-> s_reach_crc)
    else $error("frame did not reach crc beat at transfer 8");
  AST_LOW_MASK_ONES: assert property (chop_low && no_mask |-> data_reg[67:64] == 4'hf)
    else $error("lower mask nibble not forced to ones");
  AST_HIGH_NIBBLE_ONLY: assert property (chop_low |-> &{data_reg[7:4], data_reg[63:60]})
    else $error("unused upper nibble not ones");
  AST_LOW_NIBBLE_ONES: assert property (chop_high |-> &{data_reg[3:0], data_reg[67:64]})
    else $error("unused lower nibble not ones");
  AST_HIGH_MASK_ONES: assert property (chop_high && no_mask |-> data_reg[71:68] == 4'hf)
    else $error("upper mask nibble not forced to ones");
  AST_UPPER_LOW_MASK: assert property (chop_low && no_mask |-> data_reg[139:136] == 4'hf)
    else $error("upper lane mask low nibble not ones");
  AST_UPPER_HIGH_MASK: assert property (chop_high && no_mask |-> data_reg[143:140] == 4'hf)
    else $error("upper lane mask high nibble not ones");
  AST_MISMATCH_FLAG: assert property (in_crc && mismatch |=> pulse_reg && status_reg)
    else $error("mismatch did not raise error");
  AST_STICKY: assert property (status_reg && !status_clear_i |=> status_reg)
    else $error("error status dropped without clear");
  AST_NARROW_UPPER: assert property (
      in_crc && !mode_reg.wide_device && tree_out[7:0] == crc_rx[7:0] |=> !pulse_reg)
    else $error("narrow device flagged upper tree");
endmodule

/* File: src/bcm_pkg.sv */
// bcm_pkg: constants and types for the write crc input mapper
package bcm_pkg;
  localparam int unsigned TREE_WIDTH    = 72;
  localparam int unsigned TREE_COUNT    = 2;
  localparam int unsigned FULL_WIDTH    = TREE_WIDTH * TREE_COUNT;
  localparam int unsigned LANE_SLOTS    = 8;
  localparam int unsigned LANE_COUNT    = FULL_WIDTH / LANE_SLOTS;
  localparam int unsigned LOWER_MASK    = 8;
  localparam int unsigned UPPER_MASK    = 17;
  localparam int unsigned CRC_WIDTH     = 8;
  localparam int unsigned DQ_WIDTH      = 16;
  localparam logic [2:0]  CHOP_BEATS    = 3'h4;
  localparam logic [2:0]  LAST_DATA     = 3'h7;
  localparam logic [2:0]  UPPER_HALF    = 3'h4;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  SLOTS_ONES    = 8'hff;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DATA,
    ST_CRC,
    ST_TAIL
  } bcm_state_type;

  typedef struct packed {
    logic burst_chop_four;
    logic start_column_bit;
    logic mask_enable;
    logic inversion_enable;
    logic wide_device;
  } bcm_mode_type;

  typedef struct packed {
    logic                upper_mask_inversion_pin;
    logic [DQ_WIDTH-1:0] dq;
    logic                lower_mask_inversion_pin;
  } bcm_beat_type;
endpackage

/* File: tb/bcm_ctl_model.sv */
// bcm_ctl_model: controller side, drives write frames and predicts the crc result
`timescale 1ns/100ps
module bcm_ctl_model (
  input  wire logic            clock_i,
  output logic                 frame_start_o,
  output bcm_pkg::bcm_beat_type beat_o,
  output bcm_pkg::bcm_mode_type mode_o
);
  logic [15:0] exp_crc = 16'h0;
  logic [15:0] crc_mask = 16'h0;
  logic        exp_err = 1'h0;
  logic        due = 1'h0;
  initial begin
    frame_start_o = 1'h0;
    beat_o = '1;
    mode_o = '0;
  end
  // serial crc8, poly 07, bit 71 first
  function automatic logic [7:0] crc72(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h0;
    for (int i = 71; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // transfers 0..8; caller sends the next frame or idles in transfer 9
  task automatic send(input bcm_pkg::bcm_mode_type m, input logic [143:0] pl,
                      input logic [15:0] flip);
    logic [143:0] tree;
    logic [15:0]  cs;
    logic [17:0]  v;
    int           pos;
    int           b;
    tree = '1;
    for (int n = 0; n < 18; n++)
      for (int t = 0; t < 8; t++) begin
        pos = 8 * n + t + ((m.burst_chop_four && m.start_column_bit) ? 4 : 0);
        if ((!m.burst_chop_four || t < 4) && (n % 9 != 8 || m.mask_enable || m.inversion_enable))
          tree[pos] = pl[8*n+t];
      end
    cs = {crc72(tree[143:72]), crc72(tree[71:0])} ^ flip;
    for (int t = 0; t < 9; t++) begin
      @(negedge clock_i);
      frame_start_o = (t == 0);
      mode_o = (t == 0) ? m : ~m;
      for (int n = 0; n < 18; n++) begin
        b = (n < 8) ? n + 1 : ((n == 8) ? 0 : n);
        if (t == 8) v[b] = (n % 9 == 8) ? 1'h1 : cs[(n < 8) ? n : n - 1];
        else v[b] = (m.burst_chop_four && t >= 4) ? 1'h1 : pl[8*n+t];
      end
      beat_o = v;
    end
    crc_mask = m.wide_device ? 16'hffff : 16'h00ff;
    exp_crc = (cs ^ flip) & crc_mask;
    exp_err = |(flip & crc_mask);
    due = 1'h1;
  endtask
  task automatic idle();
    @(negedge clock_i);
    frame_start_o = 1'h0;
    beat_o = '1;
  endtask
endmodule

/* File: tb/testbench.sv */
// testbench: self-checking bench for the write crc input mapper
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  typedef struct packed {bcm_pkg::bcm_mode_type m; logic [15:0] flip;} bcm_row_type;
  logic                  clock = 1'h0;
  logic                  reset_n = 1'h0;
  logic                  status_clear = 1'h0;
  logic                  frame_start;
  bcm_pkg::bcm_beat_type beat;
  bcm_pkg::bcm_mode_type mode;
  logic                  err_pulse;
  logic                  err_status;
  logic                  busy;
  logic [15:0]           crc_calc;
  logic                  exp_status = 1'h0;
  int                    num_errors = 0;
  int                    check_count = 0;
  // mode {chop, start, mask, inv, wide}, crc bits flipped by the controller
  bcm_row_type rows [10] = '{{5'h14, 16'h0}, {5'h1a, 16'h0}, {5'h10, 16'h0},
    {5'h18, 16'h0001}, {5'h15, 16'h0}, {5'h1b, 16'h8000},
    {5'h19, 16'h0}, {5'h05, 16'h0}, {5'h14, 16'h0100}, {5'h11, 16'h0}};
  always #5 clock = ~clock;
  bcm_ctl_model ctl (.clock_i(clock), .frame_start_o(frame_start), .beat_o(beat), .mode_o(mode));
  bcm_crc_map dut (.clock_i(clock), .reset_n_i(reset_n), .frame_start_i(frame_start),
    .beat_i(beat), .mode_i(mode), .status_clear_i(status_clear), .crc_error_pulse_o(err_pulse),
    .crc_error_status_o(err_status), .crc_computed_o(crc_calc), .frame_busy_o(busy));
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ---------------------------------------------
  // result check in cycle 9 of every frame not cut short by reset
  // ---------------------------------------------
  always @(posedge clock) begin
    if (ctl.due) begin
      #1;
      ctl.due = 1'h0;
      exp_status = exp_status | ctl.exp_err;
      `CHK(err_pulse, ctl.exp_err)
      `CHK(crc_calc & ctl.crc_mask, ctl.exp_crc)
      `CHK(err_status, exp_status)
      `CHK(busy, 1'h0)
    end
  end
  initial begin
    #5000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    `CHK({err_pulse, err_status, crc_calc, busy}, 19'h0)
    reset_n = 1'h1;
    // back to back frames through every mode row
    foreach (rows[i]) ctl.send(rows[i].m, {3{48'h9e3779b97f4a}} ^ {18{8'(i * 37)}}, rows[i].flip);
    ctl.idle();
    @(negedge clock) status_clear = 1'h1;
    @(negedge clock) status_clear = 1'h0;
    exp_status = 1'h0;
    `CHK(err_status, 1'h0)
    // clear in the same cycle as a new error: set wins
    fork
      ctl.send(5'h18, {9{16'h5ac3}}, 16'h0002);
      begin
        repeat (9) @(negedge clock);
        `CHK(busy, 1'h1)
        status_clear = 1'h1;
        @(negedge clock) status_clear = 1'h0;
      end
    join
    ctl.idle();
    `CHK({err_pulse, err_status}, 2'h1)
    // reset in mid-frame drops result and status
    fork
      ctl.send(5'h1b, {9{16'h3c96}}, 16'h0101);
      begin
        repeat (4) @(negedge clock);
        reset_n = 1'h0;
      end
    join
    ctl.due = 1'h0;
    exp_status = 1'h0;
    @(negedge clock);
    `CHK({err_pulse, err_status, crc_calc, busy}, 19'h0)
    reset_n = 1'h1;
    ctl.send(5'h15, {9{16'h0ff0}}, 16'h0);
    ctl.idle();
    repeat (3) @(negedge clock);
    tally_and_finish();
  end
endmodule
